// *** vtms_pkg.sv ***
// Package with register map, field layout and timing constants of the velocity mode select block
package vtms_pkg;

	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;
	localparam int PERIOD_W = 20;
	localparam int DELAY_W = 8;

	// ------------------------------------------------------------
	// Register offsets
	// ------------------------------------------------------------
	localparam logic [7:0] OFS_POWERDOWN_DELAY = 8'h11;
	localparam logic [7:0] OFS_STEP_PERIOD = 8'h12;
	localparam logic [7:0] OFS_PWM_THRESHOLD = 8'h13;
	localparam logic [7:0] OFS_COOL_THRESHOLD = 8'h14;
	localparam logic [7:0] OFS_HIGH_THRESHOLD = 8'h15;
	localparam logic [7:0] OFS_MODE_CONFIG = 8'h16;
	localparam logic [7:0] OFS_MODE_STATUS = 8'h17;

	// ------------------------------------------------------------
	// Reset values
	// ------------------------------------------------------------
	localparam logic [7:0] RST_POWERDOWN_DELAY = 8'h00;
	localparam logic [19:0] RST_THRESHOLD = 20'h00000;
	localparam logic [6:0] RST_MODE_CONFIG = 7'h00;
	localparam logic [19:0] PERIOD_MAX = 20'hfffff;

	// ------------------------------------------------------------
	// Mode configuration fields
	// ------------------------------------------------------------
	localparam int CFG_PWM_MODE = 0;
	localparam int CFG_ADAPTIVE_CURRENT = 1;
	localparam int CFG_LOAD_SPEED = 2;
	localparam int CFG_STALL_STOP = 3;
	localparam int CFG_SMALL_HYST = 4;
	localparam int CFG_HIGH_CHOPPER = 5;
	localparam int CFG_HIGH_FULLSTEP = 6;
	localparam int CFG_W = 7;

	// ------------------------------------------------------------
	// Hysteresis and timing
	// ------------------------------------------------------------
	localparam int HYST_SHIFT_NORMAL = 4;
	localparam int HYST_SHIFT_SMALL = 5;
	localparam int POWERDOWN_UNIT_CYCLES = 262144;
	localparam logic [1:0] STALL_BLANK_PERIODS = 2'h3;
	localparam logic [17:0] PRESCALE_ONE = 18'h00001;

	typedef enum logic [2:0] {
		VTMS_PD_RUN = 3'b001,
		VTMS_PD_WAIT = 3'b010,
		VTMS_PD_REDUCE = 3'b100
	} vtms_pd_state_e;

endpackage

// *** vtms_hyst_compare.sv ***
// Step period compare against one threshold with hysteresis
`timescale 1ns/1ns

module vtms_hyst_compare (
	input wire logic clock,
	input wire logic reset,
	input wire logic [19:0] period,
	input wire logic [19:0] threshold,
	input wire logic small_hyst,
	output logic at_or_above
);

	// ------------------------------------------------------------
	// Second compare value
	// ------------------------------------------------------------
	// Kept 21 bits wide so a tiny threshold goes negative instead of wrapping
	logic [20:0] hyst_part;
	logic [20:0] low_value;
	logic low_negative;
	logic above_now;
	logic below_low;
	logic next_at_or_above;

	assign hyst_part = small_hyst ?
		{1'b0, threshold >> vtms_pkg::HYST_SHIFT_SMALL} :
		{1'b0, threshold >> vtms_pkg::HYST_SHIFT_NORMAL}; // RULE_04 RULE_05
	assign low_value = {1'b0, threshold} - hyst_part - 21'h000001; // RULE_06
	assign low_negative = low_value[20];
	assign above_now = period >= threshold; // RULE_20
	assign below_low = !low_negative && ({1'b0, period} <= low_value);
	assign next_at_or_above = above_now ? 1'b1 : (below_low ? 1'b0 : at_or_above);

	// ------------------------------------------------------------
	// State
	// ------------------------------------------------------------
	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			at_or_above <= 1'b1;
		end else begin
			at_or_above <= next_at_or_above; // RULE_06
		end
	end

endmodule

// *** vtms_mode_select.sv ***
// Velocity threshold mode select: step period measurement, mode switching and power-down delay
`timescale 1ns/1ns

// Functional notes
// RULE_01 - After standstill, wait power-down register times 2^18 clocks before current reduction
// RULE_02 - Measure clocks between two 1/256 microsteps, readable as 20-bit value
// RULE_03 - Step period saturates at all ones on overflow or standstill
// RULE_04 - Threshold comparisons use hysteresis of one sixteenth of threshold by default
// RULE_05 - Reduced-hysteresis flag changes hysteresis to one thirty-second
// RULE_06 - Second compare value is threshold*15/16-1 or *31/32-1
// RULE_07 - With motion controller, measured period tracks 2^24 divided by velocity
// RULE_08 - In load-speed mode, period reflects each single microstep
// RULE_09 - Period at or above PWM threshold enables PWM mode, disables load-speed control
// RULE_10 - Between adaptive and high thresholds, enable adaptive current, disable PWM
// RULE_11 - Below adaptive threshold, enable stall output and optional stop on stall
// RULE_12 - Outside load-speed mode, stall output disabled again when slower than threshold
// RULE_13 - Suppress stall detection two to three electrical periods on each high crossing
// RULE_14 - At or below high threshold, disable adaptive current and PWM mode
// RULE_15 - High velocity chopper flag forces constant off-time, fast decay zero
// RULE_16 - At high velocity, chopper synchronisation is switched off
// RULE_17 - High velocity fullstep flag selects fullstep and fullstep stall detection
// RULE_18 - Step period is clock frequency over step frequency
// RULE_19 - Current reduction begins only after standstill and expired power-down delay
// RULE_20 - Thresholds and period unsigned 20-bit, compared every clock cycle
module vtms_mode_select #(
	parameter int POWERDOWN_UNIT_CYCLES = vtms_pkg::POWERDOWN_UNIT_CYCLES
) (
	input wire logic clock,
	input wire logic reset,
	input wire logic [7:0] reg_address,
	input wire logic [31:0] reg_write_data,
	input wire logic reg_write,
	input wire logic reg_read,
	output logic [31:0] reg_read_data,
	input wire logic microstep_pulse,
	input wire logic standstill,
	input wire logic electrical_period_pulse,
	input wire logic load_speed_active,
	output logic pwm_mode_enable,
	output logic load_speed_enable,
	output logic adaptive_current_enable,
	output logic stall_output_enable,
	output logic stop_on_stall_enable,
	output logic stall_blank,
	output logic chopper_constant_off,
	output logic fast_decay_time_zero,
	output logic chopper_sync_off,
	output logic fullstep_enable,
	output logic stall_fullstep_select,
	output logic current_reduction_start
);

	// ------------------------------------------------------------
	// Registers
	// ------------------------------------------------------------
	logic [7:0] standstill_powerdown_delay;
	logic [19:0] measured_step_period;
	logic [19:0] pwm_mode_upper_threshold;
	logic [19:0] adaptive_current_lower_threshold;
	logic [19:0] high_velocity_threshold;
	logic [6:0] mode_config;

	logic hit_delay;
	logic hit_period;
	logic hit_pwm;
	logic hit_cool;
	logic hit_high;
	logic hit_config;
	logic hit_status;

	assign hit_delay = reg_address == vtms_pkg::OFS_POWERDOWN_DELAY;
	assign hit_period = reg_address == vtms_pkg::OFS_STEP_PERIOD;
	assign hit_pwm = reg_address == vtms_pkg::OFS_PWM_THRESHOLD;
	assign hit_cool = reg_address == vtms_pkg::OFS_COOL_THRESHOLD;
	assign hit_high = reg_address == vtms_pkg::OFS_HIGH_THRESHOLD;
	assign hit_config = reg_address == vtms_pkg::OFS_MODE_CONFIG;
	assign hit_status = reg_address == vtms_pkg::OFS_MODE_STATUS;

	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			standstill_powerdown_delay <= vtms_pkg::RST_POWERDOWN_DELAY;
			pwm_mode_upper_threshold <= vtms_pkg::RST_THRESHOLD;
			adaptive_current_lower_threshold <= vtms_pkg::RST_THRESHOLD;
			high_velocity_threshold <= vtms_pkg::RST_THRESHOLD;
			mode_config <= vtms_pkg::RST_MODE_CONFIG;
		end else if (reg_write) begin
			if (hit_delay) begin
				standstill_powerdown_delay <= reg_write_data[7:0];
			end
			if (hit_pwm) begin
				pwm_mode_upper_threshold <= reg_write_data[19:0]; // RULE_20
			end
			if (hit_cool) begin
				adaptive_current_lower_threshold <= reg_write_data[19:0]; // RULE_20
			end
			if (hit_high) begin
				high_velocity_threshold <= reg_write_data[19:0]; // RULE_20
			end
			if (hit_config) begin
				mode_config <= reg_write_data[6:0];
			end
		end
	end

	logic cfg_pwm;
	logic cfg_adaptive;
	logic cfg_load_speed;
	logic cfg_stall_stop;
	logic cfg_small_hyst;
	logic cfg_high_chopper;
	logic cfg_high_fullstep;

	assign cfg_pwm = mode_config[vtms_pkg::CFG_PWM_MODE];
	assign cfg_adaptive = mode_config[vtms_pkg::CFG_ADAPTIVE_CURRENT];
	assign cfg_load_speed = mode_config[vtms_pkg::CFG_LOAD_SPEED];
	assign cfg_stall_stop = mode_config[vtms_pkg::CFG_STALL_STOP];
	assign cfg_small_hyst = mode_config[vtms_pkg::CFG_SMALL_HYST];
	assign cfg_high_chopper = mode_config[vtms_pkg::CFG_HIGH_CHOPPER];
	assign cfg_high_fullstep = mode_config[vtms_pkg::CFG_HIGH_FULLSTEP];

	// ------------------------------------------------------------
	// Step period measurement
	// ------------------------------------------------------------
	// Counts clock periods since the last microstep, so the result is fCLK / fSTEP
	// and each microstep is measured on its own, with no averaging
	logic [19:0] step_count;
	logic count_full;
	logic [19:0] next_step_count;
	logic [19:0] next_step_period;

	assign count_full = step_count == vtms_pkg::PERIOD_MAX;
	assign next_step_count = microstep_pulse ? 20'h00001 :
		(count_full ? step_count : step_count + 20'h00001); // RULE_18
	assign next_step_period = standstill ? vtms_pkg::PERIOD_MAX :
		(count_full ? vtms_pkg::PERIOD_MAX : // RULE_03
		(microstep_pulse ? step_count : measured_step_period)); // RULE_02 RULE_08 RULE_07

	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			step_count <= vtms_pkg::PERIOD_MAX;
			measured_step_period <= vtms_pkg::PERIOD_MAX;
		end else begin
			step_count <= next_step_count;
			measured_step_period <= next_step_period; // RULE_02
		end
	end

	// ------------------------------------------------------------
	// Threshold comparisons
	// ------------------------------------------------------------
	// The high comparison means "period above threshold", so its compare level is one more
	logic [19:0] high_plus_one;
	logic pwm_slow;
	logic cool_slow;
	logic high_slow;

	assign high_plus_one = (high_velocity_threshold == vtms_pkg::PERIOD_MAX) ?
		vtms_pkg::PERIOD_MAX : high_velocity_threshold + 20'h00001;

	vtms_hyst_compare u_pwm_compare (
		.clock(clock),
		.reset(reset),
		.period(measured_step_period),
		.threshold(pwm_mode_upper_threshold),
		.small_hyst(cfg_small_hyst),
		.at_or_above(pwm_slow)
	); // RULE_04 RULE_05

	vtms_hyst_compare u_cool_compare (
		.clock(clock),
		.reset(reset),
		.period(measured_step_period),
		.threshold(adaptive_current_lower_threshold),
		.small_hyst(cfg_small_hyst),
		.at_or_above(cool_slow)
	); // RULE_04 RULE_05

	vtms_hyst_compare u_high_compare (
		.clock(clock),
		.reset(reset),
		.period(measured_step_period),
		.threshold(high_plus_one),
		.small_hyst(cfg_small_hyst),
		.at_or_above(high_slow)
	); // RULE_04 RULE_05

	logic cool_fast;
	logic high_fast;
	logic mid_band;

	assign cool_fast = !cool_slow;
	assign high_fast = !high_slow;
	assign mid_band = cool_fast && !high_fast;

	// ------------------------------------------------------------
	// Mode outputs
	// ------------------------------------------------------------
	logic next_pwm;
	logic next_load_speed;
	logic next_adaptive;

	assign next_pwm = cfg_pwm && pwm_slow && !mid_band && !high_fast; // RULE_09 RULE_10 RULE_14
	assign next_load_speed = cfg_load_speed && !pwm_slow; // RULE_09
	assign next_adaptive = cfg_adaptive && mid_band; // RULE_10 RULE_14

	// ------------------------------------------------------------
	// Stall enable and blanking
	// ------------------------------------------------------------
	// In load-speed mode the stall output stays on once armed, so a brief slow
	// microstep cannot hide a real stall
	logic stall_armed;
	logic next_stall_armed;
	logic high_fast_d;
	logic high_crossed;
	logic [1:0] blank_count;
	logic [1:0] next_blank_count;

	assign next_stall_armed = cool_fast ? 1'b1 :
		(load_speed_active ? stall_armed : 1'b0); // RULE_11 RULE_12
	assign high_crossed = high_fast != high_fast_d;
	// Counting three period pulses gives two to three periods depending on phase
	assign next_blank_count = high_crossed ? vtms_pkg::STALL_BLANK_PERIODS :
		((electrical_period_pulse && blank_count != 2'h0) ?
		blank_count - 2'h1 : blank_count); // RULE_13

	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			stall_armed <= 1'b0;
			high_fast_d <= 1'b0;
			blank_count <= 2'h0;
		end else begin
			stall_armed <= next_stall_armed;
			high_fast_d <= high_fast;
			blank_count <= next_blank_count;
		end
	end

	logic next_blank;
	logic next_stop_on_stall;

	assign next_blank = next_blank_count != 2'h0; // RULE_13
	assign next_stop_on_stall = next_stall_armed && cfg_stall_stop && !next_blank; // RULE_11

	// ------------------------------------------------------------
	// High velocity chopper and fullstep
	// ------------------------------------------------------------
	logic next_const_off;
	logic next_fullstep;

	assign next_const_off = high_fast && cfg_high_chopper; // RULE_15
	assign next_fullstep = high_fast && cfg_high_fullstep; // RULE_17

	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			pwm_mode_enable <= 1'b0;
			load_speed_enable <= 1'b0;
			adaptive_current_enable <= 1'b0;
			stall_output_enable <= 1'b0;
			stop_on_stall_enable <= 1'b0;
			stall_blank <= 1'b0;
			chopper_constant_off <= 1'b0;
			fast_decay_time_zero <= 1'b0;
			chopper_sync_off <= 1'b0;
			fullstep_enable <= 1'b0;
			stall_fullstep_select <= 1'b0;
		end else begin
			pwm_mode_enable <= next_pwm;
			load_speed_enable <= next_load_speed;
			adaptive_current_enable <= next_adaptive;
			stall_output_enable <= next_stall_armed && !next_blank; // RULE_11 RULE_13
			stop_on_stall_enable <= next_stop_on_stall;
			stall_blank <= next_blank;
			chopper_constant_off <= next_const_off; // RULE_15
			fast_decay_time_zero <= next_const_off; // RULE_15
			chopper_sync_off <= high_fast; // RULE_16
			fullstep_enable <= next_fullstep; // RULE_17
			stall_fullstep_select <= next_fullstep; // RULE_17
		end
	end

	// ------------------------------------------------------------
	// Standstill power-down delay
	// ------------------------------------------------------------
	// One prescaler tick every unit; the delay count starts at a fresh unit boundary
	logic [17:0] prescale;
	logic unit_tick;
	logic [7:0] unit_count;
	logic delay_done;
	vtms_pkg::vtms_pd_state_e pd_state;
	vtms_pkg::vtms_pd_state_e next_pd_state;

	assign unit_tick = prescale == 18'(POWERDOWN_UNIT_CYCLES - 1);
	assign delay_done = unit_count >= standstill_powerdown_delay; // RULE_01

	always_comb begin
		next_pd_state = pd_state;
		case (pd_state)
			vtms_pkg::VTMS_PD_RUN: begin
				if (standstill) begin
					next_pd_state = vtms_pkg::VTMS_PD_WAIT;
				end
			end
			vtms_pkg::VTMS_PD_WAIT: begin
				if (!standstill) begin
					next_pd_state = vtms_pkg::VTMS_PD_RUN;
				end else if (delay_done) begin
					next_pd_state = vtms_pkg::VTMS_PD_REDUCE; // RULE_19
				end
			end
			vtms_pkg::VTMS_PD_REDUCE: begin
				if (!standstill) begin
					next_pd_state = vtms_pkg::VTMS_PD_RUN;
				end
			end
			default: begin
				next_pd_state = vtms_pkg::VTMS_PD_RUN;
			end
		endcase
	end

	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			pd_state <= vtms_pkg::VTMS_PD_RUN;
			prescale <= 18'h00000;
			unit_count <= 8'h00;
		end else begin
			pd_state <= next_pd_state;
			if (pd_state != vtms_pkg::VTMS_PD_WAIT) begin
				prescale <= 18'h00000;
				unit_count <= 8'h00;
			end else if (unit_tick) begin
				prescale <= 18'h00000;
				unit_count <= unit_count + 8'h01; // RULE_01
			end else begin
				prescale <= prescale + vtms_pkg::PRESCALE_ONE;
			end
		end
	end

	// Held high for as long as the current stays reduced
	assign current_reduction_start = pd_state == vtms_pkg::VTMS_PD_REDUCE; // RULE_19

	// ------------------------------------------------------------
	// Read path
	// ------------------------------------------------------------
	// Threshold registers are write-only and read as zero
	logic [31:0] status_word;
	logic [31:0] read_mux;

	assign status_word = {21'h000000, current_reduction_start, stall_blank, fullstep_enable,
		chopper_constant_off, chopper_sync_off, stop_on_stall_enable, stall_output_enable,
		adaptive_current_enable, load_speed_enable, pwm_mode_enable, high_fast};
	assign read_mux = hit_period ? {12'h000, measured_step_period} :
		(hit_config ? {25'h0000000, mode_config} :
		(hit_status ? status_word : 32'h00000000));

	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			reg_read_data <= 32'h00000000;
		end else if (reg_read) begin
			reg_read_data <= read_mux;
		end else begin
			reg_read_data <= 32'h00000000;
		end
	end

endmodule

// *** vtms_mode_monitor.sv ***
// Checker of the mode select outputs and the register read port
`timescale 1ns/1ns

module vtms_mode_monitor (
	input wire logic clock,
	input wire logic reset,
	input wire logic [7:0] reg_address,
	input wire logic [31:0] reg_write_data,
	input wire logic reg_write,
	input wire logic reg_read,
	input wire logic [31:0] reg_read_data,
	input wire logic microstep_pulse,
	input wire logic standstill,
	input wire logic electrical_period_pulse,
	input wire logic load_speed_active,
	input wire logic pwm_mode_enable,
	input wire logic load_speed_enable,
	input wire logic adaptive_current_enable,
	input wire logic stall_output_enable,
	input wire logic stop_on_stall_enable,
	input wire logic stall_blank,
	input wire logic chopper_constant_off,
	input wire logic fast_decay_time_zero,
	input wire logic chopper_sync_off,
	input wire logic fullstep_enable,
	input wire logic stall_fullstep_select,
	input wire logic current_reduction_start
);
	default clocking mon_cb @(posedge clock);
	endclocking
	default disable iff (reset);

	// ------------------------------------------------------------
	// Register port
	// ------------------------------------------------------------
	a_idle_read_zero: assert property (!reg_read |=> reg_read_data == 32'h00000000)
		else $error("read data not zero outside a read");
	a_wo_read_zero: assert property (reg_read && reg_address == 8'h11 |=> reg_read_data == 32'h0)
		else $error("write-only delay register read back nonzero");
	a_saturated_read: assert property (standstill && $past(standstill) && reg_read
		&& reg_address == 8'h12 |=> reg_read_data == 32'h000fffff)
		else $error("step period not saturated at standstill");

	// ------------------------------------------------------------
	// Mode outputs
	// ------------------------------------------------------------
	a_pwm_load_split: assert property (!(pwm_mode_enable && load_speed_enable))
		else $error("pwm mode and load speed control both on");
	a_pwm_adapt_split: assert property (!(pwm_mode_enable && adaptive_current_enable))
		else $error("pwm mode and adaptive current both on");
	a_high_clears_modes: assert property (chopper_sync_off |->
		!adaptive_current_enable && !pwm_mode_enable)
		else $error("slow modes on at high velocity");
	a_decay_pair: assert property (chopper_constant_off |->
		fast_decay_time_zero && chopper_sync_off)
		else $error("constant off-time without zero fast decay at high velocity");
	a_fullstep_pair: assert property (fullstep_enable |->
		stall_fullstep_select && chopper_sync_off)
		else $error("fullstep without fullstep stall select");
	a_blank_on_cross: assert property ($changed(chopper_sync_off) |-> ##[0:2] stall_blank)
		else $error("no stall blanking after high threshold crossing");
	a_stall_unblanked: assert property (stall_output_enable |-> !stall_blank)
		else $error("stall output on while blanked");
	a_reduce_standstill: assert property (current_reduction_start |-> $past(standstill))
		else $error("current reduction without standstill");
endmodule

bind vtms_mode_select vtms_mode_monitor mon (.*);

// *** vtms_step_source.sv ***
// Step source model driving microstep and electrical period pulses
`timescale 1ns/1ns

module vtms_step_source #(
	parameter int ELEC_DIV = 4
) (
	input wire logic clock,
	input wire logic reset,
	input wire logic run,
	input wire logic [19:0] step_period,
	output logic microstep_pulse,
	output logic standstill,
	output logic electrical_period_pulse
);
	logic [19:0] count;
	logic [7:0] steps;
	wire elec_last = (steps == 8'(ELEC_DIV - 1));

	// Short electrical period keeps blanking spans small
	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			count <= 20'h00000;
			steps <= 8'h00;
			microstep_pulse <= 1'b0;
			electrical_period_pulse <= 1'b0;
			standstill <= 1'b1;
		end else begin
			standstill <= !run;
			microstep_pulse <= 1'b0;
			electrical_period_pulse <= 1'b0;
			if (!run) begin
				count <= 20'h00000;
			end else if (count >= step_period - 20'h00001) begin
				count <= 20'h00000;
				microstep_pulse <= 1'b1;
				steps <= elec_last ? 8'h00 : steps + 8'h01;
				electrical_period_pulse <= elec_last;
			end else begin
				count <= count + 20'h00001;
			end
		end
	end
endmodule

// *** velocity_threshold_mode_select_bench.sv ***
// Self-checking bench of the velocity mode select block
`timescale 1ns/1ns

module velocity_threshold_mode_select_bench;
	logic clock, reset, reg_write, reg_read, load_speed_active, run;
	logic [7:0] reg_address;
	logic [31:0] reg_write_data, rd;
	logic [19:0] step_period;
	wire logic [31:0] reg_read_data;
	wire logic microstep_pulse, standstill, electrical_period_pulse;
	wire logic pwm_mode_enable, load_speed_enable, adaptive_current_enable;
	wire logic stall_output_enable, stop_on_stall_enable, stall_blank;
	wire logic chopper_constant_off, fast_decay_time_zero, chopper_sync_off;
	wire logic fullstep_enable, stall_fullstep_select, current_reduction_start;
	wire logic [8:0] modes = {pwm_mode_enable, adaptive_current_enable, stall_output_enable,
		stop_on_stall_enable, chopper_sync_off, chopper_constant_off, fast_decay_time_zero,
		fullstep_enable, stall_fullstep_select};
	int err_count, checked, n;

	// Power-down unit shortened to 8 clocks
	vtms_mode_select #(.POWERDOWN_UNIT_CYCLES(8)) dut (
		.clock(clock),
		.reset(reset),
		.reg_address(reg_address),
		.reg_write_data(reg_write_data),
		.reg_write(reg_write),
		.reg_read(reg_read),
		.reg_read_data(reg_read_data),
		.microstep_pulse(microstep_pulse),
		.standstill(standstill),
		.electrical_period_pulse(electrical_period_pulse),
		.load_speed_active(load_speed_active),
		.pwm_mode_enable(pwm_mode_enable),
		.load_speed_enable(load_speed_enable),
		.adaptive_current_enable(adaptive_current_enable),
		.stall_output_enable(stall_output_enable),
		.stop_on_stall_enable(stop_on_stall_enable),
		.stall_blank(stall_blank),
		.chopper_constant_off(chopper_constant_off),
		.fast_decay_time_zero(fast_decay_time_zero),
		.chopper_sync_off(chopper_sync_off),
		.fullstep_enable(fullstep_enable),
		.stall_fullstep_select(stall_fullstep_select),
		.current_reduction_start(current_reduction_start)
	);

	vtms_step_source src (
		.clock(clock),
		.reset(reset),
		.run(run),
		.step_period(step_period),
		.microstep_pulse(microstep_pulse),
		.standstill(standstill),
		.electrical_period_pulse(electrical_period_pulse)
	);

	// ------------------------------------------------------------
	// Shared tasks
	// ------------------------------------------------------------
	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			err_count++;
			$display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clock);
		reg_address <= a;
		reg_write_data <= d;
		reg_write <= 1'b1;
		@(posedge clock);
		reg_write <= 1'b0;
	endtask

	task automatic rd_reg(input logic [7:0] a);
		@(posedge clock);
		reg_address <= a;
		reg_read <= 1'b1;
		@(posedge clock);
		reg_read <= 1'b0;
		#1;
		rd = reg_read_data;
	endtask

	// Three intervals let a changed period settle through the compare pipeline
	task automatic speed(input logic [19:0] p);
		@(posedge clock);
		step_period <= p;
		run <= 1'b1;
		repeat (3 * p + 10) @(posedge clock);
		#1;
	endtask

	task automatic finish_test;
		if (err_count == 0 && checked > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask

	// ------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------
	task automatic test_reset;
		rd_reg(8'h12);
		check("period at reset", rd, 32'h000fffff);
		rd_reg(8'h13);
		check("write-only read", rd, 32'h00000000);
		rd_reg(8'h30);
		check("unmapped read", rd, 32'h00000000);
	endtask

	task automatic test_period;
		speed(20'h00064);
		rd_reg(8'h12);
		check("period", rd, 32'h00000064);
		@(posedge clock);
		run <= 1'b0;
		repeat (4) @(posedge clock);
		rd_reg(8'h12);
		check("period standstill", rd, 32'h000fffff);
	endtask

	task automatic test_hold;
		speed(20'h000c8);
		check("stall below cool", stall_output_enable, 1'b1);
		speed(20'h001f4);
		check("stall off again", stall_output_enable, 1'b0);
		@(posedge clock);
		load_speed_active <= 1'b1;
		speed(20'h000c8);
		speed(20'h001f4);
		check("stall held", stall_output_enable, 1'b1);
		@(posedge clock);
		load_speed_active <= 1'b0;
		speed(20'h001f4);
		check("stall released", stall_output_enable, 1'b0);
	endtask

	task automatic test_regions;
		check("modes slow", modes, 9'h100);
		check("load speed off", load_speed_enable, 1'b0);
		speed(20'h000c8);
		check("modes mid", modes, 9'h0e0);
		check("load speed mid", load_speed_enable, 1'b1);
		@(posedge clock);
		step_period <= 20'h00032;
		n = 0;
		// Look after the edge so the registered flag has settled
		while (!chopper_sync_off && n < 400) begin
			@(posedge clock);
			#1;
			n++;
		end
		check("high reached", chopper_sync_off, 1'b1);
		repeat (3) @(posedge clock);
		#1;
		check("blank on", {stall_blank, stall_output_enable}, 2'b10);
		repeat (800) @(posedge clock);
		#1;
		check("modes fast", modes, 9'h07f);
		rd_reg(8'h17);
		check("status fast", rd, 32'h000001f5);
		speed(20'h000c8);
		check("back below high", {adaptive_current_enable, chopper_sync_off}, 2'b10);
	endtask

	// Threshold 0x140: fast at 299 normal, 309 reduced
	task automatic test_hyst;
		wr(8'h13, 32'h00000140);
		speed(20'h001f4);
		check("pwm on", pwm_mode_enable, 1'b1);
		speed(20'h00136);
		check("pwm held", pwm_mode_enable, 1'b1);
		speed(20'h0012b);
		check("pwm off", pwm_mode_enable, 1'b0);
		speed(20'h00136);
		check("pwm held off", pwm_mode_enable, 1'b0);
		speed(20'h00140);
		check("pwm on at t", pwm_mode_enable, 1'b1);
		wr(8'h16, 32'h0000007f);
		speed(20'h00131);
		check("pwm off small", pwm_mode_enable, 1'b0);
	endtask

	task automatic test_powerdown;
		wr(8'h11, 32'h00000003);
		@(posedge clock);
		run <= 1'b0;
		repeat (12) @(posedge clock);
		#1;
		check("reduce early", current_reduction_start, 1'b0);
		repeat (30) @(posedge clock);
		#1;
		check("reduce due", current_reduction_start, 1'b1);
		@(posedge clock);
		run <= 1'b1;
		repeat (5) @(posedge clock);
		#1;
		check("reduce moving", current_reduction_start, 1'b0);
	endtask

	// ------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------
	initial begin
		clock = 1'b0;
		forever #25 clock = ~clock;
	end

	initial begin
		reset = 1'b1;
		reg_write = 1'b0;
		reg_read = 1'b0;
		reg_address = 8'h00;
		reg_write_data = 32'h00000000;
		load_speed_active = 1'b0;
		run = 1'b0;
		step_period = 20'h00064;
		repeat (4) @(posedge clock);
		reset <= 1'b0;
		test_reset;
		test_period;
		wr(8'h13, 32'h00000190);
		wr(8'h14, 32'h0000012c);
		wr(8'h15, 32'h00000064);
		wr(8'h16, 32'h0000006f);
		test_hold;
		test_regions;
		test_hyst;
		test_powerdown;
		finish_test;
	end

	// Run needs about 14500 clocks
	initial begin
		repeat (60000) @(posedge clock);
		err_count++;
		finish_test;
	end
endmodule
